// ---- hw/acc_cal_ctrl.v ----
// Calibration control register block for converter cores 2 and 3.
//
// The register offsets and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "acc_defs.vh"

module acc_cal_ctrl (
  clk,
  rst,
  address,
  read,
  write,
  writedata,
  byteenable,
  readdata,
  waitrequest,
  core2_cal_complete,
  core3_cal_complete,
  core2_cal_request,
  core3_cal_request,
  core2_cal_diff_mode,
  core3_cal_diff_mode,
  irq
);
  // ----------------------------------------------------------------------
  // Clock, reset and Avalon-MM slave
  // ----------------------------------------------------------------------
  input wire clk;
  input wire rst;
  input wire [`ACC_ADDR_W-1:0] address;
  input wire read;
  input wire write;
  input wire [31:0] writedata;
  input wire [3:0] byteenable;
  output wire [31:0] readdata;
  output wire waitrequest;

  // ----------------------------------------------------------------------
  // Converter core links
  // ----------------------------------------------------------------------
  input wire core2_cal_complete;
  input wire core3_cal_complete;
  output wire core2_cal_request;
  output wire core3_cal_request;
  output wire core2_cal_diff_mode;
  output wire core3_cal_diff_mode;

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  output wire irq;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function addr_hit;
    input [`ACC_ADDR_W-1:0] addr;
    input [`ACC_ADDR_W-1:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // Software view of one core byte; all fields read zero while access is off.
  function [`ACC_CORE_W-1:0] core_byte;
    input en;
    input rdy;
    input diff;
    input run;
    begin
      core_byte = {`ACC_CORE_W{1'b0}};
      core_byte[`ACC_EN_BIT] = en;
      core_byte[`ACC_RDY_BIT] = en & rdy;
      core_byte[`ACC_DIFF_BIT] = en & diff;
      core_byte[`ACC_RUN_BIT] = en & run;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Avalon-MM handshake
  // ----------------------------------------------------------------------
  // Every access stalls for exactly one cycle, which gives the read mux a
  // full cycle and keeps the answer time fixed for software.
  reg ack_reg;
  reg [31:0] rdata_reg;
  wire req_any;
  wire wr_take;
  wire rd_first;

  assign req_any = read | write;
  assign waitrequest = req_any & ~ack_reg;
  assign wr_take = write & ack_reg;
  assign rd_first = read & ~ack_reg;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_reg <= `ACC_RST_BIT;
    end else begin
      ack_reg <= req_any & ~ack_reg;
    end
  end

  wire cal_wr;
  wire stat_wr;
  wire mask_wr;

  assign cal_wr = wr_take & addr_hit(address, `ACC_OFF_CAL);
  assign stat_wr = wr_take & addr_hit(address, `ACC_OFF_IRQ_STAT) & byteenable[0];
  assign mask_wr = wr_take & addr_hit(address, `ACC_OFF_IRQ_MASK) & byteenable[0];

  // ----------------------------------------------------------------------
  // Per-core calibration fields
  // ----------------------------------------------------------------------
  reg [`ACC_NUM_CORES-1:0] en_reg;
  reg [`ACC_NUM_CORES-1:0] diff_reg;
  reg [`ACC_NUM_CORES-1:0] run_reg;
  reg [`ACC_NUM_CORES-1:0] rdy_reg;
  wire [`ACC_NUM_CORES-1:0] start_pulse;
  wire [`ACC_NUM_CORES-1:0] start_diff;
  wire [`ACC_NUM_CORES-1:0] eng_busy;
  wire [`ACC_NUM_CORES-1:0] eng_done;
  wire [`ACC_NUM_CORES-1:0] cal_complete;
  wire [`ACC_NUM_CORES-1:0] cal_request;
  wire [`ACC_NUM_CORES-1:0] cal_diff_mode;

  assign cal_complete = {core3_cal_complete, core2_cal_complete};
  assign core2_cal_request = cal_request[0];
  assign core3_cal_request = cal_request[1];
  assign core2_cal_diff_mode = cal_diff_mode[0];
  assign core3_cal_diff_mode = cal_diff_mode[1];

  genvar gi;
  generate
    for (gi = 0; gi < `ACC_NUM_CORES; gi = gi + 1) begin : g_core
      // Core 2 owns the low byte and core 3 the high byte.
      localparam integer LSB = (gi == 0) ? `ACC_CORE2_LSB : `ACC_CORE3_LSB;
      wire lane_wr;
      wire [`ACC_CORE_W-1:0] wbyte;
      wire en_new;

      assign lane_wr = cal_wr & byteenable[gi];
      assign wbyte = writedata[LSB +: `ACC_CORE_W];
      assign en_new = wbyte[`ACC_EN_BIT];

      // The reserved bit is never stored, so software writing zero there
      // costs nothing and a stray one has no effect.
      // A start needs access enabled by the same write and no cycle running.
      // The engine must be idle as well, so a start can never cut a handshake.
      assign start_pulse[gi] = lane_wr & en_new & wbyte[`ACC_RUN_BIT] &
                               ~run_reg[gi] & ~eng_busy[gi];
      assign start_diff[gi] = wbyte[`ACC_DIFF_BIT];

      always @(posedge clk or posedge rst) begin
        if (rst) begin
          en_reg[gi] <= `ACC_RST_BIT;
          diff_reg[gi] <= `ACC_RST_BIT;
          run_reg[gi] <= `ACC_RST_BIT;
          rdy_reg[gi] <= `ACC_RST_BIT;
        end else begin
          if (lane_wr) begin
            en_reg[gi] <= en_new;
          end
          // The mode is held for the whole cycle once it has started.
          if (lane_wr && en_new && !run_reg[gi]) begin
            diff_reg[gi] <= wbyte[`ACC_DIFF_BIT];
          end
          // The done flag and the start bit move on the same edge, so software
          // never sees a finished cycle with start still set.
          // Writing zero cannot abort a cycle; only completion clears it.
          if (start_pulse[gi]) begin
            run_reg[gi] <= 1'b1;
          end else if (eng_done[gi]) begin
            run_reg[gi] <= 1'b0;
          end
          if (start_pulse[gi]) begin
            rdy_reg[gi] <= 1'b0;
          end else if (eng_done[gi]) begin
            rdy_reg[gi] <= 1'b1;
          end
        end
      end

      acc_cal_engine u_engine (
        .clk(clk),
        .rst(rst),
        .start(start_pulse[gi]),
        .diff_sel(start_diff[gi]),
        .core_cal_complete(cal_complete[gi]),
        .core_cal_request(cal_request[gi]),
        .core_cal_diff_mode(cal_diff_mode[gi]),
        .busy(eng_busy[gi]),
        .done(eng_done[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Software view of the calibration register
  // ----------------------------------------------------------------------
  // Each field has one named net, so the read path and any probe see the
  // same stored values before the access gate is applied.
  wire core2_cal_done_flag;
  wire core3_cal_done_flag;
  wire core2_cal_differential;
  wire core3_cal_differential;
  wire core2_cal_access_enable;
  wire core3_cal_access_enable;
  wire core2_cal_start;
  wire core3_cal_start;
  wire [`ACC_CORE_W-1:0] core2_cal_byte;
  wire [`ACC_CORE_W-1:0] core3_cal_byte;
  wire [15:0] converter_core_calibration_high;

  assign core2_cal_done_flag = rdy_reg[0];
  assign core3_cal_done_flag = rdy_reg[1];
  assign core2_cal_differential = diff_reg[0];
  assign core3_cal_differential = diff_reg[1];
  assign core2_cal_access_enable = en_reg[0];
  assign core3_cal_access_enable = en_reg[1];
  assign core2_cal_start = run_reg[0];
  assign core3_cal_start = run_reg[1];

  assign core2_cal_byte = core_byte(core2_cal_access_enable, core2_cal_done_flag,
                                    core2_cal_differential, core2_cal_start);
  assign core3_cal_byte = core_byte(core3_cal_access_enable, core3_cal_done_flag,
                                    core3_cal_differential, core3_cal_start);
  assign converter_core_calibration_high[`ACC_CORE2_LSB +: `ACC_CORE_W] = core2_cal_byte;
  assign converter_core_calibration_high[`ACC_CORE3_LSB +: `ACC_CORE_W] = core3_cal_byte;

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  reg [`ACC_NUM_CORES-1:0] irq_stat_reg;
  reg [`ACC_NUM_CORES-1:0] irq_stat_next;
  reg [`ACC_NUM_CORES-1:0] irq_mask_reg;

  // Status and mask follow the core order of the calibration register:
  // bit 0 is core 2 and bit 1 is core 3.
  // A completion in the cycle of a write-one clear keeps its bit set.
  always @* begin
    irq_stat_next = irq_stat_reg;
    if (stat_wr) begin
      irq_stat_next = irq_stat_reg & ~writedata[`ACC_NUM_CORES-1:0];
    end
    irq_stat_next = irq_stat_next | eng_done;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_reg <= `ACC_RST_PAIR;
      irq_mask_reg <= `ACC_RST_PAIR;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (mask_wr) begin
        irq_mask_reg <= writedata[`ACC_NUM_CORES-1:0];
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Read data is captured at the stall edge and stands for the answer edge.
  // Unmapped addresses read zero and ignore writes.
  // A completion that lands between the two edges shows on the next read;
  // software polls the done flag, so the lag costs one access at most.
  reg [31:0] rdata_mux;

  always @* begin
    rdata_mux = `ACC_RST_WORD;
    case (address)
      `ACC_OFF_CAL: begin
        rdata_mux[15:0] = converter_core_calibration_high;
      end
      `ACC_OFF_IRQ_STAT: begin
        rdata_mux[`ACC_NUM_CORES-1:0] = irq_stat_reg;
      end
      `ACC_OFF_IRQ_MASK: begin
        rdata_mux[`ACC_NUM_CORES-1:0] = irq_mask_reg;
      end
      default: begin
        rdata_mux = `ACC_RST_WORD;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= `ACC_RST_WORD;
    end else if (rd_first) begin
      rdata_reg <= rdata_mux;
    end
  end

  assign readdata = rdata_reg;

endmodule // acc_cal_ctrl

// ---- hw/acc_defs.vh ----
// Constants for the converter core calibration control block.
`ifndef ACC_DEFS_VH
`define ACC_DEFS_VH

// ----------------------------------------------------------------------
// Register byte addresses on the Avalon-MM slave
// ----------------------------------------------------------------------
`define ACC_ADDR_W 4
`define ACC_OFF_CAL 4'h0
`define ACC_OFF_IRQ_STAT 4'h4
`define ACC_OFF_IRQ_MASK 4'h8

// ----------------------------------------------------------------------
// Calibration register layout, one byte per core
// ----------------------------------------------------------------------
`define ACC_CORE_W 8
`define ACC_NUM_CORES 2
`define ACC_CORE2_LSB 0
`define ACC_CORE3_LSB 8
`define ACC_RUN_BIT 0
`define ACC_EN_BIT 1
`define ACC_DIFF_BIT 2
`define ACC_RSVD_BIT 3
`define ACC_RDY_BIT 7
`define ACC_UNIMP_W 3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ACC_RST_BIT 1'h0
`define ACC_RST_PAIR 2'h0
`define ACC_RST_WORD 32'h00000000

// ----------------------------------------------------------------------
// Calibration sequencer states
// ----------------------------------------------------------------------
`define ACC_ST_W 2
`define ACC_ST_IDLE 2'h0
`define ACC_ST_REQ 2'h1
`define ACC_ST_REL 2'h2

`endif

// ---- hw/acc_cal_engine.v ----
// Per-core calibration sequencer: handshake with one converter core.
`timescale 1ns/10ps
`include "acc_defs.vh"

module acc_cal_engine (
  clk,
  rst,
  start,
  diff_sel,
  core_cal_complete,
  core_cal_request,
  core_cal_diff_mode,
  busy,
  done
);
  input wire clk;
  input wire rst;
  input wire start;
  input wire diff_sel;
  input wire core_cal_complete;
  output wire core_cal_request;
  output wire core_cal_diff_mode;
  output wire busy;
  output wire done;

  localparam [`ACC_ST_W-1:0] ST_IDLE = `ACC_ST_IDLE;
  localparam [`ACC_ST_W-1:0] ST_REQ = `ACC_ST_REQ;
  localparam [`ACC_ST_W-1:0] ST_REL = `ACC_ST_REL;

  reg [`ACC_ST_W-1:0] state_reg;
  reg [`ACC_ST_W-1:0] state_next;
  reg sync1_reg;
  reg sync2_reg;
  reg req_reg;
  reg diff_reg;
  reg done_reg;

  // ----------------------------------------------------------------------
  // Completion input synchroniser
  // ----------------------------------------------------------------------
  // The core runs its own calibration clock, so its level crosses here.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= `ACC_RST_BIT;
      sync2_reg <= `ACC_RST_BIT;
    end else begin
      sync1_reg <= core_cal_complete;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // A cycle holds the request until the core reports completion, then
  // waits for the completion level to drop so that a stale level cannot
  // end the next cycle early.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_REQ;
        end
      end
      ST_REQ: begin
        if (sync2_reg) begin
          state_next = ST_REL;
        end
      end
      ST_REL: begin
        if (!sync2_reg) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      req_reg <= `ACC_RST_BIT;
      diff_reg <= `ACC_RST_BIT;
      done_reg <= `ACC_RST_BIT;
    end else begin
      state_reg <= state_next;
      done_reg <= (state_reg == ST_REL) && !sync2_reg;
      if (state_reg == ST_IDLE && start) begin
        req_reg <= 1'b1;
        diff_reg <= diff_sel;
      end else if (state_reg == ST_REQ && sync2_reg) begin
        req_reg <= 1'b0;
      end
    end
  end

  assign core_cal_request = req_reg;
  assign core_cal_diff_mode = diff_reg;
  assign busy = (state_reg != ST_IDLE);
  assign done = done_reg;

endmodule // acc_cal_engine

// ---- testbench/acc_cal_ctrl_checker.sv ----
// Port-level assertions for the calibration control block.
`timescale 1ns/10ps
module acc_cal_ctrl_checker (
  input wire clk,
  input wire rst,
  input wire [3:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire core2_cal_complete,
  input wire core3_cal_complete,
  input wire core2_cal_request,
  input wire core3_cal_request,
  input wire core2_cal_diff_mode,
  input wire core3_cal_diff_mode
);
  wire bus_req = read | write;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_wait_first: assert property ($rose(bus_req) |-> waitrequest)
    else $error("no wait cycle");
  a_wait_once: assert property (bus_req && waitrequest |=> !waitrequest)
    else $error("wait longer than one cycle");
  a_upper_zero: assert property (read && !waitrequest |-> readdata[31:16] == 16'h0000)
    else $error("upper half not zero");
  a_unimp_zero: assert property (read && !waitrequest && address == 4'h0
    |-> readdata[14:11] == 4'h0 && readdata[6:3] == 4'h0) else $error("unused bits set");
  a_c2_start: assert property ($rose(core2_cal_request) |-> $past(write && !waitrequest
    && address == 4'h0 && byteenable[0] && writedata[1:0] == 2'h3)
    && core2_cal_diff_mode == $past(writedata[2])) else $error("core2 bad start");
  a_c3_start: assert property ($rose(core3_cal_request) |-> $past(write && !waitrequest
    && address == 4'h0 && byteenable[1] && writedata[9:8] == 2'h3)
    && core3_cal_diff_mode == $past(writedata[10])) else $error("core3 bad start");
  a_c2_release: assert property ($rose(core2_cal_complete) |-> ##[1:3] !core2_cal_request)
    else $error("core2 request stuck");
  a_c3_release: assert property ($rose(core3_cal_complete) |-> ##[1:3] !core3_cal_request)
    else $error("core3 request stuck");
endmodule // acc_cal_ctrl_checker

bind acc_cal_ctrl acc_cal_ctrl_checker u_acc_cal_ctrl_checker (.clk(clk), .rst(rst),
  .address(address), .read(read), .write(write), .writedata(writedata),
  .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
  .core2_cal_complete(core2_cal_complete), .core3_cal_complete(core3_cal_complete),
  .core2_cal_request(core2_cal_request), .core3_cal_request(core3_cal_request),
  .core2_cal_diff_mode(core2_cal_diff_mode), .core3_cal_diff_mode(core3_cal_diff_mode));

// ---- testbench/tb_acc_cal_ctrl.sv ----
// Self-checking bench for the calibration control block.
`timescale 1ns/10ps
module tb_acc_cal_ctrl;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] address = 4'h0;
  reg read = 1'b0;
  reg write = 1'b0;
  reg [31:0] writedata = 32'h0;
  reg [3:0] byteenable = 4'hF;
  reg [1:0] done_in = 2'h0;
  reg [31:0] rd;
  wire [31:0] readdata;
  wire waitrequest;
  wire [1:0] req;
  wire [1:0] mode;
  wire irq;
  integer bad_count = 0;
  integer checks_done = 0;

  always #5 clk = ~clk;

  acc_cal_ctrl u_acc_cal_ctrl (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .core2_cal_complete(done_in[0]),
    .core3_cal_complete(done_in[1]), .core2_cal_request(req[0]), .core3_cal_request(req[1]),
    .core2_cal_diff_mode(mode[0]), .core3_cal_diff_mode(mode[1]), .irq(irq));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task report_and_stop;
    begin
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // Values are sampled just at the edge, so they are the settled pre-edge ones.
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      @(posedge clk);
      while (waitrequest !== 1'b0) begin
        @(posedge clk);
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
    end
  endtask

  task calib(input integer c, input [31:0] wr, input m, input [31:0] exp);
    integer n;
    begin
      bus(1'b1, 4'h0, wr);
      bus(1'b0, 4'h0, 32'h0);
      check(rd[8*c+7], 1'b0);
      check({req, mode[c]}, {2'h1 << c, m});
      done_in[c] <= 1'b1;
      n = 0;
      while (req[c] !== 1'b0 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      check(req[c], 1'b0);
      done_in[c] <= 1'b0;
      n = 0;
      do begin
        bus(1'b0, 4'h0, 32'h0);
        n = n + 1;
      end while (rd[8*c] === 1'b1 && n < 10);
      check(rd, exp);
    end
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 4'h8, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 4'hC, 32'hFFFF);
    bus(1'b0, 4'hC, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 4'h0, 32'h0505);
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0);
    check(req, 2'h0);
    bus(1'b1, 4'h0, 32'h7676);
    bus(1'b0, 4'h0, 32'h0);
    check(rd, 32'h0606);
    calib(0, 32'h0607, 1'b1, 32'h0686);
    bus(1'b0, 4'h4, 32'h0);
    check(rd, 32'h1);
    check(irq, 1'b0);
    bus(1'b1, 4'h8, 32'h3);
    check(irq, 1'b1);
    bus(1'b1, 4'h4, 32'h1);
    check(irq, 1'b0);
    calib(1, 32'h0306, 1'b0, 32'h8286);
    bus(1'b0, 4'h4, 32'h0);
    check(rd, 32'h2);
    check(irq, 1'b1);
    bus(1'b1, 4'h8, 32'h0);
    check(irq, 1'b0);
    report_and_stop;
  end

  // A hang in any wait ends the run as a failure.
  initial begin
    #100000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
endmodule // tb_acc_cal_ctrl
